// *** rtl/dfe_front_end.sv ***
// Input front end of the downconverter: sample intake, gain offset,
// serial carrier offset loader, and a crossing into the back-end clock.
// Assumes ref_clk is the input sample clock and backEndClock is unrelated.
//
// Notes on behaviour
// - Input section logic runs on the rising edge of the input clock.
// - Samples are 14 bits, offset binary or two's complement by control.
// - Active-low sample enable qualifies input, gated or interpolated by control.
// - Gated mode takes one sample per input clock with enable asserted.
// - Gain offset pins are added to the software shift code.
// - The summed shift code saturates at F, never wraps.
// - Each gain offset step is 6 dB, top pin is the MSB.
// - Everything after the filter input runs on the back-end clock.
// - Back-end clock may be asynchronous; crossings are synchronised.
// - All output-side timing comes from the back-end clock.
// - Loop gain select is sampled on back-end clock; high picks setting 1.
// - Carrier offset word loads serially, 8, 16, 24 or 32 bits long.
//
// Chosen here: strobed register access and the register addresses.
`include "dfe_consts.svh"
`timescale 1ns/100ps
`default_nettype none
module dfe_front_end (
	// Input clock domain
	input  wire logic             ref_clk,
	input  wire logic             rst,
	// Converter pins
	input  wire logic [13:0]      sampleIn,
	input  wire logic             sampleEnableN,
	input  wire logic [2:0]       gainOffsetPins,
	// Carrier offset serial pins
	input  wire logic             carrierOffsetSerialIn,
	input  wire logic             carrierOffsetSync,
	// Register port
	input  wire dfe_pkg::dfe_bus_t bus,
	output logic [31:0]           rdData,
	// Front status
	output logic [3:0]            shiftCode,
	output logic [31:0]           cofWord,
	output logic                  cofLoad,
	output logic                  frontReady,
	// Back-end clock domain
	input  wire logic             backEndClock,
	input  wire logic             loopGainSelect,
	input  wire logic             outReady,
	output dfe_pkg::dfe_sample_t  outData,
	output logic                  outValid,
	output logic                  loopGainSel
);
	dfe_pkg::dfe_fe_t fe_r;
	dfe_pkg::dfe_fe_t fe_nxt;
	dfe_pkg::dfe_be_t be_r;
	dfe_pkg::dfe_be_t be_nxt;
	logic             feFull;
	logic             bePop;
	logic             beEmpty;

	// Buffer state seen by each side
	assign feFull  = (fe_r.wGray == ~fe_r.rGrayS2);
	assign beEmpty = (be_r.rGray == be_r.wGrayS2);
	assign bePop   = !beEmpty && (!be_r.outValid || outReady);

	// Input domain next state
	always_comb begin
		logic [4:0]  sum;
		logic [13:0] smp;
		logic        push;
		logic [5:0]  len;
		logic [31:0] nreg;
		sum = 5'h00;
		smp = 14'h0000;
		push = 1'b0;
		len = 6'h00;
		nreg = 32'h0000_0000;
		fe_nxt = fe_r;
		// Two flops on every pin before use
		fe_nxt.pinS1.data    = sampleIn;
		fe_nxt.pinS1.enN     = sampleEnableN;
		fe_nxt.pinS1.gain    = gainOffsetPins;
		fe_nxt.pinS1.cof     = carrierOffsetSerialIn;
		fe_nxt.pinS1.carrier_offset_sync = carrierOffsetSync;
		fe_nxt.pinS2         = fe_r.pinS1;
		fe_nxt.rGrayS1       = be_r.rGray;
		fe_nxt.rGrayS2       = fe_r.rGrayS1;
		fe_nxt.cofLoad       = 1'b0;
		fe_nxt.rdData        = 32'h0000_0000;
		// Register writes
		if (bus.wr) begin
			case (bus.addr)
				`DFE_ADDR_CTRL: begin
					fe_nxt.ctrl.fmtTwos = bus.wdata[`DFE_CTRL_FMT];
					fe_nxt.ctrl.interp  = bus.wdata[`DFE_CTRL_MODE];
					fe_nxt.ctrl.shiftSw = bus.wdata[`DFE_CTRL_SHIFT];
					fe_nxt.ctrl.lenSel  = bus.wdata[`DFE_CTRL_LEN];
				end
				`DFE_ADDR_STAT: begin
					if (bus.wdata[`DFE_STAT_DROP]) begin
						fe_nxt.dropped = 1'b0;
					end
				end
				default: begin
				end
			endcase
		end
		// Register reads, data in the next cycle only
		if (bus.rd) begin
			case (bus.addr)
				`DFE_ADDR_CTRL: begin
					fe_nxt.rdData[`DFE_CTRL_FMT]   = fe_r.ctrl.fmtTwos;
					fe_nxt.rdData[`DFE_CTRL_MODE]  = fe_r.ctrl.interp;
					fe_nxt.rdData[`DFE_CTRL_SHIFT] = fe_r.ctrl.shiftSw;
					fe_nxt.rdData[`DFE_CTRL_LEN]   = fe_r.ctrl.lenSel;
				end
				`DFE_ADDR_COF: begin
					fe_nxt.rdData = fe_r.cofWord;
				end
				`DFE_ADDR_STAT: begin
					fe_nxt.rdData[`DFE_STAT_DROP]  = fe_r.dropped;
					fe_nxt.rdData[`DFE_STAT_BUSY]  = fe_r.shActive;
					fe_nxt.rdData[`DFE_STAT_SHIFT] = fe_r.shiftCode;
				end
				default: begin
				end
			endcase
		end
		// Gain offset added to the shift code, 6 dB per step
		sum = {1'b0, fe_r.ctrl.shiftSw} + {2'b00, fe_r.pinS2.gain};
		if (sum > {1'b0, `DFE_SHIFT_MAX}) begin
			fe_nxt.shiftCode = `DFE_SHIFT_MAX;
		end else begin
			fe_nxt.shiftCode = sum[3:0];
		end
		// Format conversion to two's complement
		smp = fe_r.pinS2.data;
		if (!fe_r.ctrl.fmtTwos) begin
			smp[13] = ~smp[13];
		end
		// Enable qualification
		if (fe_r.ctrl.interp) begin
			push = 1'b1;
			if (fe_r.pinS2.enN) begin
				smp = 14'h0000;
			end
		end else begin
			push = !fe_r.pinS2.enN;
		end
		// Write into the crossing buffer, a full buffer drops the sample
		if (push) begin
			if (!feFull) begin
				fe_nxt.mem[fe_r.wBin[0]] = smp;
				fe_nxt.wBin  = fe_r.wBin + 2'b01;
				fe_nxt.wGray = {fe_nxt.wBin[1], fe_nxt.wBin[1] ^ fe_nxt.wBin[0]};
			end else begin
				fe_nxt.dropped = 1'b1; // Set wins over clear
			end
		end
		// Older read pointer: ready may show late, never falsely early
		fe_nxt.frontReady = (fe_nxt.wGray != ~fe_r.rGrayS2);
		// Serial carrier offset loader, MSB first after the sync pulse
		len = {4'h0, fe_r.ctrl.lenSel} * `DFE_BYTE_BITS + `DFE_BYTE_BITS;
		nreg = {fe_r.shReg[30:0], fe_r.pinS2.cof};
		if (fe_r.pinS2.carrier_offset_sync) begin
			fe_nxt.shActive = 1'b1;
			fe_nxt.bitCnt   = 6'h00;
		end else if (fe_r.shActive) begin
			fe_nxt.shReg  = nreg;
			fe_nxt.bitCnt = fe_r.bitCnt + 6'h01;
			if (fe_r.bitCnt == len - 6'h01) begin
				fe_nxt.shActive = 1'b0;
				fe_nxt.cofWord  = nreg << (`DFE_WORD_BITS - len);
				fe_nxt.cofLoad  = 1'b1;
			end
		end
		// Synchronous reset
		if (rst) begin
			fe_nxt = '0;
			fe_nxt.frontReady = 1'b1;
			// Enable flops rest at the pin's idle high level, so no false sample follows reset
			fe_nxt.pinS1.enN  = 1'b1;
			fe_nxt.pinS2.enN  = 1'b1;
		end
	end

	// Input domain registers
	always_ff @(posedge ref_clk) begin
		fe_r <= fe_nxt;
	end

	// Back-end domain next state
	always_comb begin
		be_nxt = be_r;
		be_nxt.rstS1   = rst;
		be_nxt.rstS2   = be_r.rstS1;
		be_nxt.wGrayS1 = fe_r.wGray;
		be_nxt.wGrayS2 = be_r.wGrayS1;
		be_nxt.gainS1  = loopGainSelect;
		be_nxt.gainS2  = be_r.gainS1;
		be_nxt.gainSel = be_r.gainS2;
		// Hand samples on, holding each until taken
		// Only gray pointers cross; a slot is read once its pointer has settled here
		if (!be_r.outValid || outReady) begin
			be_nxt.outValid = 1'b0;
		end
		if (bePop) begin
			be_nxt.outData.data = fe_r.mem[be_r.rBin[0]];
			be_nxt.outValid     = 1'b1;
			be_nxt.rBin  = be_r.rBin + 2'b01;
			be_nxt.rGray = {be_nxt.rBin[1], be_nxt.rBin[1] ^ be_nxt.rBin[0]};
		end
		// Reset arrives through its own two flops
		if (be_r.rstS2) begin
			be_nxt.wGrayS1  = 2'b00;
			be_nxt.wGrayS2  = 2'b00;
			be_nxt.rBin     = 2'b00;
			be_nxt.rGray    = 2'b00;
			be_nxt.outData  = '0;
			be_nxt.outValid = 1'b0;
			be_nxt.gainSel  = 1'b0;
		end
	end

	// Back-end domain registers
	always_ff @(posedge backEndClock) begin
		be_r <= be_nxt;
	end

	// Outputs straight from flops
	assign rdData      = fe_r.rdData;
	assign shiftCode   = fe_r.shiftCode;
	assign cofWord     = fe_r.cofWord;
	assign cofLoad     = fe_r.cofLoad;
	assign frontReady  = fe_r.frontReady;
	assign outData     = be_r.outData;
	assign outValid    = be_r.outValid;
	assign loopGainSel = be_r.gainSel;

	// Checks, input domain
	sequence gatedTake_s;
		!fe_r.ctrl.interp && !fe_r.pinS2.enN && !feFull;
	endsequence

	sequence byteWord_s;
		(fe_r.pinS2.carrier_offset_sync && fe_r.ctrl.lenSel == 2'b00) ##1 (!fe_r.pinS2.carrier_offset_sync)[*8];
	endsequence

	shiftSat_a: assert property (@(posedge ref_clk) disable iff (rst)
		(({1'b0, fe_r.ctrl.shiftSw} + {2'b00, fe_r.pinS2.gain}) > 5'h0F) |=> (fe_r.shiftCode == `DFE_SHIFT_MAX))
		else $error("shift code not saturated");

	gatedTake_a: assert property (@(posedge ref_clk) disable iff (rst)
		gatedTake_s |=> (fe_r.wBin == $past(fe_r.wBin) + 2'b01))
		else $error("gated sample not taken");

	gatedSkip_a: assert property (@(posedge ref_clk) disable iff (rst)
		(!fe_r.ctrl.interp && fe_r.pinS2.enN) |=> $stable(fe_r.wGray))
		else $error("sample taken while enable high");

	zeroFill_a: assert property (@(posedge ref_clk) disable iff (rst)
		(fe_r.ctrl.interp && fe_r.pinS2.enN && !feFull) |=> (fe_r.mem[$past(fe_r.wBin[0])] == 14'h0000))
		else $error("interpolated gap not zero");

	offsetBin_a: assert property (@(posedge ref_clk) disable iff (rst)
		(gatedTake_s and !fe_r.ctrl.fmtTwos) |=> (fe_r.mem[$past(fe_r.wBin[0])][13] != $past(fe_r.pinS2.data[13])))
		else $error("offset binary sign not flipped");

	byteLoad_a: assert property (@(posedge ref_clk) disable iff (rst)
		byteWord_s |=> cofLoad)
		else $error("eight bit offset word not loaded");

	// Loader and shift code checks
	sequence halfWord_s;
		(!fe_r.pinS2.carrier_offset_sync && fe_r.ctrl.lenSel == 2'b01)[*8];
	endsequence

	wordLoad_a: assert property (@(posedge ref_clk) disable iff (rst)
		(fe_r.pinS2.carrier_offset_sync && fe_r.ctrl.lenSel == 2'b01) ##1 halfWord_s ##1 halfWord_s |=> cofLoad)
		else $error("sixteen bit offset word not loaded");

	// A sync pulse always restarts the loader from bit zero
	loadStart_a: assert property (@(posedge ref_clk) disable iff (rst)
		fe_r.pinS2.carrier_offset_sync |=> (fe_r.shActive && fe_r.bitCnt == 6'h00))
		else $error("loader not restarted by sync");

	loadPulse_a: assert property (@(posedge ref_clk) disable iff (rst)
		cofLoad |=> !cofLoad)
		else $error("load pulse longer than one cycle");

	loadEnd_a: assert property (@(posedge ref_clk) disable iff (rst)
		cofLoad |-> !fe_r.shActive)
		else $error("loader still busy after load");

	cofHold_a: assert property (@(posedge ref_clk) disable iff (rst)
		!cofLoad |-> $stable(cofWord))
		else $error("offset word changed without a load");

	shiftSum_a: assert property (@(posedge ref_clk) disable iff (rst)
		(({1'b0, fe_r.ctrl.shiftSw} + {2'b00, fe_r.pinS2.gain}) <= 5'h0F) |=> (fe_r.shiftCode == $past(fe_r.ctrl.shiftSw) + $past(fe_r.pinS2.gain)))
		else $error("shift code not the plain sum");

	// Buffer checks
	interpPush_a: assert property (@(posedge ref_clk) disable iff (rst)
		(fe_r.ctrl.interp && !feFull) |=> (fe_r.wBin == $past(fe_r.wBin) + 2'b01))
		else $error("interpolated sample not taken");

	fullStop_a: assert property (@(posedge ref_clk) disable iff (rst)
		feFull |=> $stable(fe_r.wBin))
		else $error("write into a full buffer");

	fullFlag_a: assert property (@(posedge ref_clk) disable iff (rst)
		feFull |-> !frontReady)
		else $error("ready shown while buffer full");

	dropSet_a: assert property (@(posedge ref_clk) disable iff (rst)
		((fe_r.ctrl.interp || !fe_r.pinS2.enN) && feFull) |=> fe_r.dropped)
		else $error("lost sample not flagged");

	// Register port check
	readIdle_a: assert property (@(posedge ref_clk) disable iff (rst)
		!bus.rd |=> (rdData == 32'h0000_0000))
		else $error("read data held past its cycle");

	// Checks, back-end domain
	gainPick_a: assert property (@(posedge backEndClock) disable iff (be_r.rstS2)
		(be_r.gainS2 ##1 be_r.gainS2) |=> loopGainSel)
		else $error("loop gain select not followed");

	outHold_a: assert property (@(posedge backEndClock) disable iff (be_r.rstS2)
		(outValid && !outReady) |=> (outValid && $stable(outData)))
		else $error("output dropped while stalled");

	noUnderrun_a: assert property (@(posedge backEndClock) disable iff (be_r.rstS2)
		!$stable(be_r.rGray) |-> $past(be_r.rGray != be_r.wGrayS2))
		else $error("read from empty buffer");

	gainLow_a: assert property (@(posedge backEndClock) disable iff (be_r.rstS2)
		(!be_r.gainS2 ##1 !be_r.gainS2) |=> !loopGainSel)
		else $error("loop gain select not followed low");

	validDrop_a: assert property (@(posedge backEndClock) disable iff (be_r.rstS2)
		(outValid && outReady && beEmpty) |=> !outValid)
		else $error("output valid without a new sample");
endmodule
`default_nettype wire

// *** rtl/dfe_consts.svh ***
// Constants of the downconverter input front end.
// Assumes inclusion by bare name from the package and the design.
`ifndef DFE_CONSTS_SVH
`define DFE_CONSTS_SVH
// Register indexes on the plain register port
`define DFE_ADDR_CTRL 4'h0
`define DFE_ADDR_COF 4'h1
`define DFE_ADDR_STAT 4'h2
// Control register fields
`define DFE_CTRL_FMT 0
`define DFE_CTRL_MODE 1
`define DFE_CTRL_SHIFT 7:4
`define DFE_CTRL_LEN 9:8
// Status register fields
`define DFE_STAT_DROP 0
`define DFE_STAT_BUSY 1
`define DFE_STAT_SHIFT 7:4
// Shift code saturation point
`define DFE_SHIFT_MAX 4'hF
// Serial word length: one byte per step of the length field
`define DFE_BYTE_BITS 6'h08
`define DFE_WORD_BITS 6'h20
`endif

// *** rtl/dfe_pkg.sv ***
// Types shared by the downconverter input front end.
// Assumes the constants header is on the include path.
`include "dfe_consts.svh"
package dfe_pkg;
	// Register port request
	typedef struct packed {
		logic [3:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} dfe_bus_t;
	// One converted input sample
	typedef struct packed {
		logic [13:0] data;
	} dfe_sample_t;
	// Pins as sampled in the input clock domain
	typedef struct packed {
		logic [13:0] data;
		logic        enN;
		logic [2:0]  gain;
		logic        cof;
		logic        carrier_offset_sync;
	} dfe_pin_t;
	// Software control
	typedef struct packed {
		logic       fmtTwos;
		logic       interp;
		logic [3:0] shiftSw;
		logic [1:0] lenSel;
	} dfe_ctrl_t;
	// Input clock domain state
	typedef struct packed {
		dfe_pin_t         pinS1;
		dfe_pin_t         pinS2;
		dfe_ctrl_t        ctrl;
		logic [31:0]      rdData;
		logic             dropped;
		logic [3:0]       shiftCode;
		logic             shActive;
		logic [5:0]       bitCnt;
		logic [31:0]      shReg;
		logic [31:0]      cofWord;
		logic             cofLoad;
		logic [1:0][13:0] mem;
		logic [1:0]       wBin;
		logic [1:0]       wGray;
		logic [1:0]       rGrayS1;
		logic [1:0]       rGrayS2;
		logic             frontReady;
	} dfe_fe_t;
	// Back-end clock domain state
	typedef struct packed {
		logic        rstS1;
		logic        rstS2;
		logic [1:0]  wGrayS1;
		logic [1:0]  wGrayS2;
		logic [1:0]  rBin;
		logic [1:0]  rGray;
		dfe_sample_t outData;
		logic        outValid;
		logic        gainS1;
		logic        gainS2;
		logic        gainSel;
	} dfe_be_t;
endpackage

// *** verif/dfe_cof_source.sv ***
// Serial carrier offset source: a sync pulse, then the word MSB first.
// Assumes the bench pulses go once with a left-justified word and its length.
`timescale 1ns/100ps
`default_nettype none
module dfe_cof_source (
	// Clock and command
	input  wire logic        ref_clk,
	input  wire logic        go,
	input  wire logic [31:0] word,
	input  wire logic [5:0]  nBits,
	// Serial pins
	output var logic         serialOut = 1'b0,
	output var logic         syncOut = 1'b0,
	output var logic         busy = 1'b0
);
	logic [5:0] idx = 6'h00;
	// Frame on the input clock; a finished frame leaves the inverse bit on the line
	always @(posedge ref_clk) begin
		syncOut <= 1'b0;
		if (go && !busy) begin
			busy <= 1'b1;
			idx <= 6'h00;
			syncOut <= 1'b1;
		end else if (busy && idx == nBits) begin
			busy <= 1'b0;
			serialOut <= ~serialOut;
		end else if (busy) begin
			serialOut <= word[5'h1F - idx[4:0]];
			idx <= idx + 6'h01;
		end
	end
endmodule
`default_nettype wire

// *** verif/test_ddc_input_front_end.sv ***
// Bench of the input front end: registers, shift code, sample stream, loader, loop gain.
// Assumes the design files and the serial source model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module test_ddc_input_front_end;
	logic                 ref_clk = 1'b0;
	logic                 backEndClock = 1'b0;
	logic                 rst = 1'b1;
	logic [13:0]          sampleIn = 14'h0000;
	logic                 sampleEnableN = 1'b1;
	logic [2:0]           gainOffsetPins = 3'h0;
	logic                 cofIn;
	logic                 carrier_offset_sync;
	logic                 go = 1'b0;
	logic [31:0]          word = 32'h0;
	logic [5:0]           nBits = 6'h08;
	dfe_pkg::dfe_bus_t    bus = '0;
	logic [31:0]          rdData;
	logic [3:0]           shiftCode;
	logic [31:0]          cofWord;
	logic                 cofLoad;
	logic                 frontReady;
	logic                 loopGainSelect = 1'b0;
	logic                 outReady = 1'b0;
	dfe_pkg::dfe_sample_t outData;
	logic                 outValid;
	logic                 loopGainSel;
	logic                 stall = 1'b0;
	logic                 zeroMode = 1'b0;
	logic [13:0]          expQ[$];
	logic [31:0]          d;
	int                   recvCount = 0;
	int                   r0;
	int                   bad_count = 0;
	int                   num_checks = 0;
	int                   cycles = 0;

	dfe_front_end dut (.ref_clk(ref_clk), .rst(rst), .sampleIn(sampleIn), .sampleEnableN(sampleEnableN),
		.gainOffsetPins(gainOffsetPins), .carrierOffsetSerialIn(cofIn), .carrierOffsetSync(carrier_offset_sync),
		.bus(bus), .rdData(rdData), .shiftCode(shiftCode), .cofWord(cofWord), .cofLoad(cofLoad),
		.frontReady(frontReady), .backEndClock(backEndClock), .loopGainSelect(loopGainSelect),
		.outReady(outReady), .outData(outData), .outValid(outValid), .loopGainSel(loopGainSel));
	dfe_cof_source src (.ref_clk(ref_clk), .go(go), .word(word), .nBits(nBits), .serialOut(cofIn),
		.syncOut(carrier_offset_sync), .busy());

	// Two unrelated clocks
	initial begin
		forever #5 ref_clk = ~ref_clk;
	end
	initial begin
		forever #6.5 backEndClock = ~backEndClock;
	end

	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus.wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus.rd <= 1'b0;
		#1 d = rdData;
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	function automatic logic [3:0] expShift(input logic [3:0] sw, input logic [2:0] g);
		logic [4:0] s;
		s = {1'b0, sw} + {2'b00, g};
		return (s > 5'h0F) ? 4'hF : s[3:0];
	endfunction
	function automatic logic [13:0] expConv(input logic twos, input logic [13:0] v);
		return twos ? v : {~v[13], v[12:0]};
	endfunction

	// Consumer with random stalls; every accepted sample is compared
	always @(posedge backEndClock) begin
		if (outValid === 1'b1 && outReady) begin
			recvCount++;
			if (zeroMode) chk("zero sample", 32'h0, 32'(outData.data));
			else if (expQ.size() > 0) chk("sample", 32'(expQ.pop_front()), 32'(outData.data));
			else chk("extra sample", 32'h0, 32'h1);
		end
		outReady <= stall ? 1'b0 : ($urandom % 4 != 0);
	end
	// Hang guard
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			final_report();
		end
	end

	initial begin
		void'($urandom(32'hBC9A));
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		#1 chk("frontReady", 32'h1, 32'(frontReady));
		chk("outValid", 32'h0, 32'(outValid));
		// Control readback, unmapped read, read data for one cycle only
		d = $urandom & 32'h0000_03F1;
		wr(4'h0, d);
		r0 = d;
		rd(4'h0);
		chk("ctrl", 32'(r0), d);
		rd(4'h3);
		chk("unmapped", 32'h0, d);
		@(posedge ref_clk);
		#1 chk("rdData idle", 32'h0, rdData);
		// Shift code over every gain code, saturating corner included
		for (int g = 0; g < 8; g++) begin
			logic [3:0] sw;
			sw = g[0] ? 4'hF : 4'($urandom);
			wr(4'h0, {24'h0, sw, 4'h1});
			gainOffsetPins <= g[2:0];
			repeat (5) @(posedge ref_clk);
			#1 chk("shiftCode", 32'(expShift(sw, g[2:0])), 32'(shiftCode));
		end
		// Gated stream, two's complement then offset binary, codes 2000 and 1FFF first
		for (int i = 0; i < 16; i++) begin
			logic [13:0] v;
			v = (i % 8 == 0) ? 14'h2000 : (i % 8 == 1) ? 14'h1FFF : 14'($urandom);
			if (i % 8 == 0) wr(4'h0, {31'h0, i < 8});
			@(posedge ref_clk);
			sampleIn <= v;
			sampleEnableN <= 1'b0;
			expQ.push_back(expConv(i < 8, v));
			@(posedge ref_clk);
			sampleEnableN <= 1'b1;
			sampleIn <= ~v;
			repeat (8) @(posedge ref_clk);
		end
		repeat (40) @(posedge ref_clk);
		chk("samples left", 32'h0, 32'(expQ.size()));
		rd(4'h2);
		chk("no drop", 32'h0, 32'(d[0]));
		// Interpolated with a stalled receiver: zeros fill the buffer, the rest drop
		stall <= 1'b1;
		zeroMode <= 1'b1;
		sampleIn <= 14'h1555;
		repeat (4) @(posedge ref_clk);
		r0 = recvCount;
		wr(4'h0, 32'h2);
		repeat (20) @(posedge ref_clk);
		#1 chk("frontReady full", 32'h0, 32'(frontReady));
		wr(4'h0, 32'h0);
		rd(4'h2);
		chk("drop set", 32'h1, 32'(d[0]));
		wr(4'h2, 32'h1);
		rd(4'h2);
		chk("drop cleared", 32'h0, 32'(d[0]));
		stall <= 1'b0;
		repeat (30) @(posedge ref_clk);
		chk("drained", 32'h3, 32'(recvCount - r0));
		zeroMode <= 1'b0;
		// Serial loader at every word length
		for (int n = 0; n < 4; n++) begin
			logic [31:0] w;
			w = $urandom << (24 - 8 * n);
			wr(4'h0, {22'h0, n[1:0], 8'h0});
			@(posedge ref_clk);
			word <= w;
			nBits <= 6'(8 * (n + 1));
			go <= 1'b1;
			@(posedge ref_clk);
			go <= 1'b0;
			for (int k = 0; k < 60; k++) begin
				@(posedge ref_clk);
				#1 if (cofLoad === 1'b1) break;
			end
			chk("cofWord", w, cofWord);
			rd(4'h1);
			chk("cof register", w, d);
		end
		// Loop gain select: three back-end edges, not two
		for (int b = 1; b >= 0; b--) begin
			@(posedge backEndClock);
			loopGainSelect <= b[0];
			repeat (2) @(posedge backEndClock);
			#1 chk("loopGainSel early", 32'(!b[0]), 32'(loopGainSel));
			repeat (2) @(posedge backEndClock);
			#1 chk("loopGainSel", 32'(b[0]), 32'(loopGainSel));
		end
		final_report();
	end
endmodule
`default_nettype wire
